/* pll_ovr_pkg.sv */
// Constants shared by the loop override block and its serial port
package pll_ovr_pkg;
    // Serial frame: read flag, 15-bit address, 8-bit data
    localparam int          SPI_ADDR_W     = 15;
    localparam int          SPI_DATA_W     = 8;
    localparam logic [4:0]  SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0]  SPI_ADDR_LAST  = 5'h0f;
    localparam logic [4:0]  SPI_DATA_FIRST = 5'h10;
    // Register offsets
    localparam logic [14:0] PLL_PIN_OVERRIDE_ADDR     = 15'h0058;
    localparam logic [14:0] OSCILLATOR_FREQ_TRIM_ADDR = 15'h0059;
    localparam logic [14:0] PLL_SOFT_RESET_ADDR       = 15'h005c;
    // Reset values
    localparam logic [7:0]  PLL_PIN_OVERRIDE_RST      = 8'h00;
    localparam logic [6:0]  OSCILLATOR_FREQ_TRIM_RST  = 7'h00;
    localparam logic        PLL_SOFT_RESET_RST        = 1'b0;
    // Field positions in the override and soft reset registers
    localparam int OVERRIDE_ENABLE_BIT   = 7;
    localparam int SECOND_DIVREF_MODE_HI = 5;
    localparam int SECOND_DIVREF_MODE_LO = 4;
    localparam int FIRST_DIVREF_MODE_HI  = 3;
    localparam int FIRST_DIVREF_MODE_LO  = 2;
    localparam int SINGLE_ENDED_REF_BIT  = 1;
    localparam int LOOP_ENABLE_VALUE_BIT = 0;
    localparam int LOOP_SOFT_RESET_BIT   = 0;
    // Divided-reference output modes
    localparam logic [1:0] DIVREF_OFF  = 2'h0;
    localparam logic [1:0] DIVREF_DIV1 = 2'h1;
    localparam logic [1:0] DIVREF_DIV2 = 2'h2;
    localparam logic [1:0] DIVREF_DIV4 = 2'h3;
endpackage

/* pll_pin_override_and_trim_ctrl.sv */
// Loop pin override, oscillator trim and soft reset register block
// Contract
// - Override set: loop controls come from registers
// - Override clear: loop controls follow strap pins
// - Bits 5:4 set second divided-reference mode
// - Bits 3:2 set first divided-reference mode
// - Without override, mode fields have no effect
// - Second output runs only with first output
// - Override bit 1 selects single-ended reference
// - Override bit 0 enables the loop
// - Seven-bit trim, loadable by calibration, readable
// - Soft reset release starts enabled calibration
// - Done reported after calibration or skip
`timescale 1ns/1ps
module pll_pin_override_and_trim_ctrl
    import pll_ovr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_csn_i,
    input  wire logic       spi_sdi_i,
    input  wire logic       loop_enable_pin_i,
    input  wire logic       reference_type_pin_i,
    input  wire logic       clock_strap_0_i,
    input  wire logic       clock_strap_1_i,
    input  wire logic       calibration_enable_i,
    input  wire logic       cal_finish_i,
    input  wire logic       cal_trim_load_i,
    input  wire logic [6:0] cal_trim_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    output logic            loop_enable_o,
    output logic            single_ended_ref_select_o,
    output logic [1:0]      first_divref_mode_o,
    output logic [1:0]      second_divref_mode_o,
    output logic            loop_soft_reset_o,
    output logic [6:0]      oscillator_freq_trim_o,
    output logic            cal_start_o,
    output logic            calibration_done_o
);
    typedef enum logic [1:0] {CAL_HOLD, CAL_RUN, CAL_DONE} cal_state_t;

    typedef struct packed {
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [7:0] ovr;
        logic [6:0] trim;
        logic       srst;
        cal_state_t cal;
        logic       loop_en;
        logic       se_ref;
        logic [1:0] first_mode;
        logic [1:0] second_mode;
        logic       cal_start;
        logic       cal_done;
    } ctrl_state_t;

    ctrl_state_t               s_reg;
    ctrl_state_t               s_next;
    logic                      wr;
    logic [SPI_ADDR_W-1:0]     addr;
    logic [SPI_DATA_W-1:0]     wdata;
    logic [SPI_DATA_W-1:0]     rdata;
    logic                      ovr_en;
    logic [1:0]                first_sel;
    logic [1:0]                second_sel;

    spi_reg_port u_port (
        .ref_clk_i    (ref_clk_i),
        .resetn_i     (resetn_i),
        .spi_sclk_i   (spi_sclk_i),
        .spi_csn_i    (spi_csn_i),
        .spi_sdi_i    (spi_sdi_i),
        .rdata_i      (rdata),
        .spi_sdo_o    (spi_sdo_o),
        .spi_sdo_oe_o (spi_sdo_oe_o),
        .wr_o         (wr),
        .addr_o       (addr),
        .wdata_o      (wdata)
    );

    // Read mux; unmapped offsets read as zero
    always_comb begin
        unique case (addr)
            PLL_PIN_OVERRIDE_ADDR:     rdata = s_reg.ovr;
            OSCILLATOR_FREQ_TRIM_ADDR: rdata = {1'b0, s_reg.trim};
            PLL_SOFT_RESET_ADDR:       rdata = {7'h00, s_reg.srst};
            default:                   rdata = 8'h00;
        endcase
    end

    assign ovr_en = s_reg.ovr[OVERRIDE_ENABLE_BIT];

    // Override fields pick each divided-reference mode; without override, straps pick undivided output or off
    always_comb begin
        if (ovr_en) begin
            first_sel  = s_reg.ovr[FIRST_DIVREF_MODE_HI:FIRST_DIVREF_MODE_LO];
            second_sel = s_reg.ovr[SECOND_DIVREF_MODE_HI:
                                   SECOND_DIVREF_MODE_LO];
        end else begin
            first_sel  = s_reg.pin_s2[2] ? DIVREF_DIV1 : DIVREF_OFF;
            second_sel = s_reg.pin_s2[3] ? DIVREF_DIV1 : DIVREF_OFF;
        end
    end

    // Next state: pin sync, register writes, output selection, calibration
    always_comb begin
        s_next        = s_reg;
        s_next.pin_s1 = {clock_strap_1_i, clock_strap_0_i,
                         reference_type_pin_i, loop_enable_pin_i};
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.cal_start = 1'b0;
        if (wr && addr == PLL_PIN_OVERRIDE_ADDR) begin
            s_next.ovr = wdata;
        end
        if (wr && addr == PLL_SOFT_RESET_ADDR) begin
            s_next.srst = wdata[LOOP_SOFT_RESET_BIT];
        end
        // Engine load wins; software must not write mid-calibration anyway
        if (cal_trim_load_i) begin
            s_next.trim = cal_trim_i;
        end else if (wr && addr == OSCILLATOR_FREQ_TRIM_ADDR) begin
            s_next.trim = wdata[6:0];
        end
        s_next.loop_en = ovr_en ? s_reg.ovr[LOOP_ENABLE_VALUE_BIT]
                                : s_reg.pin_s2[0];
        s_next.se_ref  = ovr_en ? s_reg.ovr[SINGLE_ENDED_REF_BIT]
                                : s_reg.pin_s2[1];
        s_next.first_mode  = first_sel;
        // Second output is gated off while the first is off
        s_next.second_mode = (first_sel == DIVREF_OFF) ? DIVREF_OFF
                                                       : second_sel;
        unique case (s_reg.cal)
            CAL_HOLD: begin
                if (!s_reg.srst) begin
                    s_next.cal       = calibration_enable_i ? CAL_RUN
                                                            : CAL_DONE;
                    s_next.cal_start = calibration_enable_i;
                end
            end
            CAL_RUN: begin
                if (s_reg.srst) begin
                    s_next.cal = CAL_HOLD;
                end else if (cal_finish_i) begin
                    s_next.cal = CAL_DONE;
                end
            end
            CAL_DONE: begin
                if (s_reg.srst) begin
                    s_next.cal = CAL_HOLD;
                end
            end
            default: s_next.cal = CAL_HOLD;
        endcase
        s_next.cal_done = (s_next.cal == CAL_DONE);
    end

    // Single state register; reset starts the calibration tracker held
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg      <= '0;
            s_reg.ovr  <= PLL_PIN_OVERRIDE_RST;
            s_reg.trim <= OSCILLATOR_FREQ_TRIM_RST;
            s_reg.srst <= PLL_SOFT_RESET_RST;
            s_reg.cal  <= CAL_HOLD;
        end else begin
            s_reg <= s_next;
        end
    end

    assign loop_enable_o             = s_reg.loop_en;
    assign single_ended_ref_select_o = s_reg.se_ref;
    assign first_divref_mode_o       = s_reg.first_mode;
    assign second_divref_mode_o      = s_reg.second_mode;
    assign loop_soft_reset_o         = s_reg.srst;
    assign oscillator_freq_trim_o    = s_reg.trim;
    assign cal_start_o               = s_reg.cal_start;
    assign calibration_done_o        = s_reg.cal_done;

    // Checks on the driven outputs
    a_ovr_loop_enable: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) ovr_en |=> loop_enable_o ==
        $past(s_reg.ovr[0])) else $error("loop enable not from reg");
    a_ovr_ref_select: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) ovr_en |=> single_ended_ref_select_o ==
        $past(s_reg.ovr[1])) else $error("ref select not from reg");
    a_pin_loop_enable: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) !ovr_en |=> loop_enable_o ==
        $past(s_reg.pin_s2[0])) else $error("loop enable not pin");
    a_ovr_first_mode: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) ovr_en |=> first_divref_mode_o ==
        $past(s_reg.ovr[3:2])) else $error("first mode wrong");
    a_ovr_second_mode: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) (ovr_en && s_reg.ovr[3:2] != 2'h0) |=>
        second_divref_mode_o == $past(s_reg.ovr[5:4]))
        else $error("second mode wrong");
    a_pin_modes: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) !ovr_en |=> first_divref_mode_o ==
        {1'b0, $past(s_reg.pin_s2[2])}) else $error("strap ignored");
    a_second_gated: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) first_divref_mode_o == 2'h0 |->
        second_divref_mode_o == 2'h0) else $error("second runs alone");
    a_write_applies: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) (wr && addr == PLL_PIN_OVERRIDE_ADDR &&
        wdata[7]) |=> ##1 loop_enable_o == $past(wdata[0], 2))
        else $error("override write late");
    a_trim_load: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) cal_trim_load_i |=>
        oscillator_freq_trim_o == $past(cal_trim_i))
        else $error("trim not loaded");
    a_cal_start: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) (s_reg.cal == CAL_HOLD && !s_reg.srst &&
        calibration_enable_i) |=> cal_start_o && !calibration_done_o)
        else $error("calibration not started");
    a_cal_skip_done: assert property (@(posedge ref_clk_i)
        disable iff (!resetn_i) (s_reg.cal == CAL_HOLD && !s_reg.srst &&
        !calibration_enable_i) |=> calibration_done_o)
        else $error("skip not done");
endmodule

/* pll_pin_override_and_trim_ctrl_tb.sv */
// Self-checking bench for the loop override, trim and soft reset block
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin check_count++; if ((e) !== (g)) begin \
    n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module pll_pin_override_and_trim_ctrl_tb
    import pll_ovr_pkg::*;
;
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] exp;
    } note_t;
    logic       ref_clk_i = 1'b0;
    logic       resetn_i;
    logic       sclk, csn, sdi, sdo, sdo_oe;
    logic       le_pin, ref_pin, strap0, strap1;
    logic       cal_en, cal_fin, trim_ld;
    logic [6:0] cal_trim, trim_o;
    logic       le_o, se_o, soft_o, start_o, done_o;
    logic [1:0] first_o, second_o;
    logic [7:0] rd_byte, oe_byte, ovr_m;
    logic [31:0] rnd = 32'hef37;
    logic       soft_m, done_m;
    note_t      note_q[$];
    event       obs_ev;
    int         n_fail = 0;
    int         check_count = 0;
    int         starts = 0;
    int         s0;
    wire [7:0]  outs = {done_o, soft_o, le_o, se_o, first_o, second_o};

    pll_pin_override_and_trim_ctrl u_pll_pin_override_and_trim_ctrl (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
        .spi_csn_i(csn), .spi_sdi_i(sdi), .loop_enable_pin_i(le_pin),
        .reference_type_pin_i(ref_pin), .clock_strap_0_i(strap0),
        .clock_strap_1_i(strap1), .calibration_enable_i(cal_en),
        .cal_finish_i(cal_fin), .cal_trim_load_i(trim_ld),
        .cal_trim_i(cal_trim), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
        .loop_enable_o(le_o), .single_ended_ref_select_o(se_o),
        .first_divref_mode_o(first_o), .second_divref_mode_o(second_o),
        .loop_soft_reset_o(soft_o), .oscillator_freq_trim_o(trim_o),
        .cal_start_o(start_o), .calibration_done_o(done_o));

    // Clock at 125 MHz
    always #4 ref_clk_i = ~ref_clk_i;

    // Start pulses last one cycle; the falling edge sees each exactly once
    always @(negedge ref_clk_i) begin
        if (start_o === 1'b1) starts++;
    end

    // Monitor: oldest note against what the design shows now
    always @(obs_ev) begin
        note_t n;
        n = note_q.pop_front();
        case (n.kind)
            2'h0: `CHECK("loop outputs", n.exp, outs)
            2'h1: `CHECK("read data", n.exp, rd_byte)
            2'h2: `CHECK("trim output", n.exp, {1'b0, trim_o})
            2'h3: `CHECK("drive enable", n.exp, oe_byte)
        endcase
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Expected loop outputs from the override byte or from the pins
    function automatic logic [7:0] exp_outs();
        logic [1:0] f, s;
        logic       le, se;
        le = ovr_m[7] ? ovr_m[0] : le_pin;
        se = ovr_m[7] ? ovr_m[1] : ref_pin;
        f  = ovr_m[7] ? ovr_m[3:2] : {1'b0, strap0};
        s  = ovr_m[7] ? ovr_m[5:4] : {1'b0, strap1};
        if (f == DIVREF_OFF) s = DIVREF_OFF;
        return {done_m, soft_m, le, se, f, s};
    endfunction

    task automatic note(input logic [1:0] k, input logic [7:0] e);
        note_q.push_back('{k, e});
        ->obs_ev;
        @(negedge ref_clk_i);
    endtask

    // One mode-0 frame; sclk halves of 6 clocks leave room for sync flops
    task automatic spi(input logic rd, input logic [14:0] a,
                       input logic [7:0] d);
        logic [23:0] f;
        f = {rd, a, d};
        rd_byte = 8'h00;
        oe_byte = 8'h00;
        csn = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        for (int i = 23; i >= 0; i--) begin
            sdi = f[i];
            repeat (6) @(negedge ref_clk_i);
            sclk = 1'b1;
            if (i < 8) rd_byte = {rd_byte[6:0], sdo};
            if (i < 8) oe_byte = {oe_byte[6:0], sdo_oe};
            repeat (6) @(negedge ref_clk_i);
            sclk = 1'b0;
        end
        repeat (6) @(negedge ref_clk_i);
        csn = 1'b1;
        sdi = 1'b0;
        repeat (12) @(negedge ref_clk_i);
    endtask

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00);
        note(2'h1, e);
        // Read data pin must be driven for every data bit of a read
        note(2'h3, 8'hff);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: runs out only if the sequence stalls
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end

    initial begin
        resetn_i = 1'b0;
        {sclk, sdi, le_pin, ref_pin, strap0, strap1} = 6'h00;
        {cal_en, cal_fin, trim_ld} = 3'h0;
        csn = 1'b1;
        cal_trim = 7'h00;
        ovr_m = 8'h00;
        soft_m = 1'b0;
        done_m = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        // Reset values, skipped calibration, unmapped place reads zero
        note(2'h0, exp_outs());
        rd_chk(PLL_PIN_OVERRIDE_ADDR, PLL_PIN_OVERRIDE_RST);
        rd_chk(OSCILLATOR_FREQ_TRIM_ADDR, 8'h00);
        rd_chk(PLL_SOFT_RESET_ADDR, 8'h00);
        rd_chk(15'h005a, 8'h00);
        $display("test reset values done");
        // Pin mode: mode fields written but the straps rule
        ovr_m = 8'h3c;
        spi(1'b0, PLL_PIN_OVERRIDE_ADDR, ovr_m);
        for (int k = 0; k < 6; k++) begin
            rnd = xs(rnd);
            {le_pin, ref_pin, strap0, strap1} = rnd[3:0];
            repeat (6) @(negedge ref_clk_i);
            note(2'h0, exp_outs());
        end
        $display("test pin mode done");
        // Override mode: every pair of divider modes, random enables
        for (int k = 0; k < 16; k++) begin
            rnd = xs(rnd);
            ovr_m = {2'b10, k[3:0], rnd[1:0]};
            spi(1'b0, PLL_PIN_OVERRIDE_ADDR, ovr_m);
            note(2'h0, exp_outs());
            rd_chk(PLL_PIN_OVERRIDE_ADDR, ovr_m);
        end
        $display("test override mode done");
        // Trim written, read back, then loaded by the calibration engine
        rnd = xs(rnd);
        // Calibration is idle here, so trim accesses are allowed
        spi(1'b0, OSCILLATOR_FREQ_TRIM_ADDR, {1'b0, rnd[6:0]});
        rd_chk(OSCILLATOR_FREQ_TRIM_ADDR, {1'b0, rnd[6:0]});
        note(2'h2, {1'b0, rnd[6:0]});
        cal_trim = ~rnd[6:0];
        trim_ld = 1'b1;
        @(negedge ref_clk_i);
        trim_ld = 1'b0;
        note(2'h2, {1'b0, ~rnd[6:0]});
        rd_chk(OSCILLATOR_FREQ_TRIM_ADDR, {1'b0, ~rnd[6:0]});
        $display("test trim done");
        // Soft reset holds calibration; release starts it when enabled
        for (int k = 0; k < 2; k++) begin
            spi(1'b0, PLL_SOFT_RESET_ADDR, 8'h01);
            soft_m = 1'b1;
            done_m = 1'b0;
            note(2'h0, exp_outs());
            rd_chk(PLL_SOFT_RESET_ADDR, 8'h01);
            cal_en = (k == 0);
            s0 = starts;
            spi(1'b0, PLL_SOFT_RESET_ADDR, 8'h00);
            soft_m = 1'b0;
            done_m = (k != 0);
            note(2'h0, exp_outs());
            `CHECK("start pulses", (k == 0) ? 1 : 0, starts - s0)
            cal_fin = 1'b1;
            @(negedge ref_clk_i);
            cal_fin = 1'b0;
            repeat (2) @(negedge ref_clk_i);
            done_m = 1'b1;
            note(2'h0, exp_outs());
        end
        $display("test calibration done");
        summarize();
    end
endmodule

/* spi_reg_port.sv */
// Serial register port: oversampled mode-0 slave giving write strobes
`timescale 1ns/1ps
module spi_reg_port
    import pll_ovr_pkg::*;
(
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  spi_sclk_i,
    input  wire logic                  spi_csn_i,
    input  wire logic                  spi_sdi_i,
    input  wire logic [SPI_DATA_W-1:0] rdata_i,
    output logic                       spi_sdo_o,
    output logic                       spi_sdo_oe_o,
    output logic                       wr_o,
    output logic [SPI_ADDR_W-1:0]      addr_o,
    output logic [SPI_DATA_W-1:0]      wdata_o
);
    typedef struct packed {
        logic [2:0]            s1;
        logic [2:0]            s2;
        logic                  sclk_prev;
        logic [4:0]            cnt;
        logic [15:0]           sh;
        logic                  rd;
        logic [SPI_DATA_W-1:0] dout;
        logic                  sdo;
        logic                  oe;
        logic                  wr;
        logic [SPI_ADDR_W-1:0] addr;
        logic [SPI_DATA_W-1:0] wdata;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;
    logic        rise;
    logic        fall;

    // Edges are taken only from the second sync stage
    assign rise = s_reg.s2[2] & ~s_reg.sclk_prev;
    assign fall = ~s_reg.s2[2] & s_reg.sclk_prev;

    // Frame decode; chip select high aborts any partial frame
    always_comb begin
        s_next           = s_reg;
        s_next.wr        = 1'b0;
        s_next.s1        = {spi_sclk_i, spi_csn_i, spi_sdi_i};
        s_next.s2        = s_reg.s1;
        s_next.sclk_prev = s_reg.s2[2];
        if (s_reg.s2[1]) begin
            s_next.cnt = 5'h00;
            s_next.oe  = 1'b0;
        end else begin
            if (rise) begin
                s_next.sh  = {s_reg.sh[14:0], s_reg.s2[0]};
                s_next.cnt = s_reg.cnt + 5'h01;
                if (s_reg.cnt == SPI_ADDR_LAST) begin
                    s_next.rd   = s_reg.sh[14];
                    s_next.addr = {s_reg.sh[13:0], s_reg.s2[0]};
                end
                if (s_reg.cnt == SPI_FRAME_LAST) begin
                    s_next.wr    = ~s_reg.rd;
                    s_next.wdata = {s_reg.sh[6:0], s_reg.s2[0]};
                    s_next.cnt   = 5'h00;
                end
            end
            // Read data launched on falling edges, valid before next rise
            if (fall && s_reg.cnt == SPI_DATA_FIRST) begin
                s_next.dout = rdata_i;
                s_next.sdo  = rdata_i[SPI_DATA_W-1];
                s_next.oe   = s_reg.rd;
            end else if (fall && s_reg.cnt > SPI_DATA_FIRST) begin
                s_next.dout = {s_reg.dout[SPI_DATA_W-2:0], 1'b0};
                s_next.sdo  = s_reg.dout[SPI_DATA_W-2];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_reg    <= '0;
            // Sync stages start at the idle chip-select level, deselected
            s_reg.s1 <= 3'h2;
            s_reg.s2 <= 3'h2;
        end else begin
            s_reg <= s_next;
        end
    end

    assign spi_sdo_o    = s_reg.sdo;
    assign spi_sdo_oe_o = s_reg.oe;
    assign wr_o         = s_reg.wr;
    assign addr_o       = s_reg.addr;
    assign wdata_o      = s_reg.wdata;
endmodule
